// [bench/lxio_checker.sv]
// Port-timing checker for the laser I/O sequencer
`timescale 1ns/10ps
`default_nettype none
module lxio_checker #(
  parameter int unsigned POST_CYC = 50
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Watched inputs
  input wire logic laser_start,
  input wire logic [4:0] schedule_select,
  input wire logic delivery_path_one_select,
  input wire logic delivery_path_two_select,
  input wire logic [1:0] delivery_path_hi_select,
  input wire logic [1:0] accept_sel,
  input wire logic time_shared_mode,
  // Watched outputs
  input wire logic ext_receivable,
  input wire logic high_voltage_on,
  input wire logic end_out,
  input wire logic monitor_normal,
  input wire logic monitor_trouble,
  input wire logic [4:0] schedule_number,
  input wire logic [3:0] delivery_enable,
  input wire logic emission
);
  // Start-held and since-emission counters
  logic [31:0] st_q, st_d, pe_q, pe_d;
  logic [3:0] sel;
  assign sel = {delivery_path_hi_select, delivery_path_two_select, delivery_path_one_select};
  // Next counts
  always_comb begin
    st_d = laser_start ? st_q + 1 : '0;
    pe_d = emission ? '0 : pe_q + 1;
  end
  // Counter registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      {st_q, pe_q} <= '0;
    end else begin
      {st_q, pe_q} <= {st_d, pe_d};
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_ext_gates_out: assert property ((emission || high_voltage_on) |->
    ext_receivable || $past(ext_receivable)) else $error("output while panel control");
  a_start_accept_time: assert property ($rose(emission) && accept_sel == 2'h1 |->
    st_q >= 2000) else $error("emission before acceptance time");
  a_stop_on_open: assert property ($fell(laser_start) |-> ##[1:6] !emission)
    else $error("emission kept after start opened");
  a_end_post_time: assert property ($rose(end_out) |->
    pe_q >= POST_CYC && pe_q <= POST_CYC + 4) else $error("end output off time");
  a_monitor_with_end: assert property ($rose(end_out) |-> monitor_normal != monitor_trouble
    && !$past(monitor_normal || monitor_trouble)) else $error("monitor result wrong");
  a_sched_from_pins: assert property ($changed(schedule_number) |->
    schedule_number == $past(schedule_select, 3)) else $error("schedule not from pins");
  a_share_together: assert property (emission && !time_shared_mode |->
    delivery_enable == sel) else $error("shared units not together");
  a_time_one_unit: assert property (emission && time_shared_mode |->
    $onehot0(delivery_enable) && (delivery_enable & ~sel) == 4'h0) else $error("slot unit wrong");
endmodule : lxio_checker
bind lxio_sequencer lxio_checker #(.POST_CYC(POST_CYC)) chk (.sys_clk, .rstn, .laser_start,
  .schedule_select, .delivery_path_one_select, .delivery_path_two_select,
  .delivery_path_hi_select, .accept_sel, .time_shared_mode, .ext_receivable, .high_voltage_on,
  .end_out, .monitor_normal, .monitor_trouble, .schedule_number, .delivery_enable, .emission);
`default_nettype wire

// [bench/lxio_plc_model.sv]
// Controller model driving the device's control lines
`timescale 1ns/10ps
`default_nettype none
module lxio_plc_model #(
  parameter int SHUT_CYC = 20
) (
  // Clock
  input wire logic sys_clk,
  // Control lines, all open at start
  output var logic ext_control_closed,
  output var logic high_voltage_request,
  output var logic [4:0] schedule_select,
  output var logic [3:0] beam_select,
  output var logic resonator_shutter_open,
  output var logic laser_start
);
  initial {ext_control_closed, high_voltage_request, schedule_select, beam_select,
    resonator_shutter_open, laser_start} = '0;
  // Changeover and high-voltage levels
  task automatic lines(input logic ext, input logic hv);
    @(negedge sys_clk);
    {ext_control_closed, high_voltage_request} = {ext, hv};
  endtask : lines
  // Schedule and beams held, shutter, shortened shutter wait, start held
  task automatic shot(input logic [4:0] s, input logic [3:0] b, input int hold);
    @(negedge sys_clk);
    {schedule_select, beam_select, resonator_shutter_open} = {s, b, 1'b1};
    repeat (SHUT_CYC) @(negedge sys_clk);
    laser_start = 1'b1;
    repeat (hold) @(negedge sys_clk);
    laser_start = 1'b0;
  endtask : shot
endmodule : lxio_plc_model
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the laser I/O sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic time_shared_mode = 1'b0;
  logic [15:0] pulse_energy = 16'h0000;
  logic [1:0] accept_sel = 2'h1;
  logic charge_done = 1'b0;
  logic ext_control_closed, high_voltage_request, resonator_shutter_open, laser_start;
  logic ext_receivable, high_voltage_on, ready, end_out, monitor_normal, monitor_trouble;
  logic emission;
  logic prev_end = 1'b0;
  logic prev_em = 1'b0;
  logic [4:0] schedule_select, schedule_number;
  logic [3:0] beam, delivery_enable;
  logic [3:0] seen = 4'h0;
  logic [10:0] want;
  logic [10:0] exp_q[$];
  logic [4:0] modes[4] = '{5'h03, 5'h01, 5'h1f, 5'h16};
  int err_total = 0;
  int n_compared = 0;
  int shots = 0;
  initial forever #25 sys_clk = ~sys_clk;
  lxio_plc_model plc (.sys_clk, .ext_control_closed, .high_voltage_request, .schedule_select,
    .beam_select(beam), .resonator_shutter_open, .laser_start);
  lxio_sequencer #(.CHARGE_CYC(100), .POST_CYC(50), .SLOT_CYC(10)) uut (.sys_clk, .rstn,
    .ext_control_closed, .high_voltage_request, .schedule_select, .resonator_shutter_open,
    .delivery_path_one_select(beam[0]), .delivery_path_two_select(beam[1]),
    .delivery_path_hi_select(beam[3:2]), .laser_start, .accept_sel, .time_shared_mode,
    .charge_done, .pulse_energy, .energy_low_limit(16'h1000),
    .energy_high_limit(16'h2000), .ext_receivable, .high_voltage_on, .ready, .end_out,
    .monitor_normal, .monitor_trouble, .schedule_number, .delivery_enable, .emission);
  // Scoreboard: gather units lit, compare when end output rises
  always @(posedge sys_clk) begin
    prev_end <= end_out;
    prev_em <= emission;
    if (emission && !prev_em) shots <= shots + 1;
    seen <= (end_out && !prev_end) ? 4'h0 : emission ? seen | delivery_enable : seen;
    if (end_out && !prev_end) begin
      want = (exp_q.size() == 0) ? 11'h7ff : exp_q.pop_front();
      `CHK({schedule_number, seen, monitor_normal, monitor_trouble}, want)
    end
  end
  // Verdict and end of run
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  // One shot with random schedule and energy, bounded wait for end
  task automatic fire(input logic [4:0] m);
    logic [4:0] s;
    logic ok;
    @(negedge sys_clk);
    s = 5'($urandom);
    pulse_energy = 16'($urandom_range(0, 12287));
    if (pulse_energy == 16'h1000 || pulse_energy == 16'h2000) pulse_energy = 16'h0000;
    ok = pulse_energy > 16'h1000 && pulse_energy < 16'h2000;
    time_shared_mode = m[4];
    exp_q.push_back({s, m[3:0], ok, !ok});
    plc.shot(s, m[3:0], 2100);
    for (int i = 0; i < 400 && end_out !== 1'b1; i++) @(negedge sys_clk);
    if (end_out !== 1'b1) begin
      err_total++;
      conclude();
    end
  endtask : fire
  // Main sequence
  initial begin
    void'($urandom(32'h0000_dc75));
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    plc.lines(1'b0, 1'b1);
    plc.shot(5'h15, 4'h3, 2100);
    `CHK({ext_receivable, high_voltage_on, ready, emission, schedule_number}, 9'h000)
    plc.lines(1'b1, 1'b1);
    for (int i = 0; i < 108 && ready !== 1'b1; i++) @(negedge sys_clk);
    `CHK({ext_receivable, high_voltage_on, ready}, 3'h7)
    // Drop the request, then let the charger report done early
    plc.lines(1'b1, 1'b0);
    repeat (4) @(negedge sys_clk);
    `CHK({high_voltage_on, ready}, 2'h0)
    charge_done = 1'b1;
    plc.lines(1'b1, 1'b1);
    repeat (4) @(negedge sys_clk);
    `CHK(ready, 1'b1)
    charge_done = 1'b0;
    foreach (modes[k]) fire(modes[k]);
    plc.shot(5'h1f, 4'h3, 100);
    repeat (300) @(negedge sys_clk);
    `CHK({emission, shots == 4}, 2'h1)
    // Longer acceptance setting must refuse a start held only 0.1 ms
    accept_sel = 2'h2;
    plc.shot(5'h1f, 4'h3, 2100);
    repeat (300) @(negedge sys_clk);
    `CHK({emission, shots == 4}, 2'h1)
    conclude();
  end
endmodule : testbench
`default_nettype wire

// [rtl/lxio_sequencer.sv]
// Laser external I/O handshake sequencer
// Overview of operation
// - Ready within 31 s of high-voltage request
// - Emission after start held acceptance time
// - Four acceptance settings, 16/0.1/4/8 ms
// - End output 40 ms after emission
// - Monitor result 40 ms after emission
// - Time-shared mode steps units one to four
// - Outside time-shared mode, up to four selected beams share one emission simultaneously
// - External control only when changeover closed
// - Emit while start closed, stop when opened
`timescale 1ns/10ps
`default_nettype none
`include "lxio_defines.svh"
module lxio_sequencer #(
  parameter int unsigned CHARGE_CYC = `LXIO_CHARGE_CYC,
  parameter int unsigned POST_CYC = `LXIO_POST_CYC,
  parameter int unsigned SLOT_CYC = 20000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Controller pins
  input wire logic ext_control_closed,
  input wire logic high_voltage_request,
  input wire logic [4:0] schedule_select,
  input wire logic delivery_path_one_select,
  input wire logic delivery_path_two_select,
  input wire logic [1:0] delivery_path_hi_select,
  input wire logic resonator_shutter_open,
  input wire logic laser_start,
  // Configuration and internal status
  input wire logic [1:0] accept_sel,
  input wire logic time_shared_mode,
  input wire logic charge_done,
  input wire logic [15:0] pulse_energy,
  input wire logic [15:0] energy_low_limit,
  input wire logic [15:0] energy_high_limit,
  // Device outputs
  output logic ext_receivable,
  output logic high_voltage_on,
  output logic ready,
  output logic end_out,
  output logic monitor_normal,
  output logic monitor_trouble,
  output logic [4:0] schedule_number,
  output logic [3:0] delivery_enable,
  output logic emission
);
  // Pin inputs on two-stage synchronisers
  localparam int NPIN = 13;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_q;
  logic [NPIN-1:0] sync2_q;
  assign pin_raw = {ext_control_closed, high_voltage_request, schedule_select,
                    delivery_path_one_select, delivery_path_two_select,
                    delivery_path_hi_select, resonator_shutter_open, laser_start};
  // Two flip-flops per pin
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end
  logic ext_s, hv_s, shut_s, start_s;
  logic [4:0] sched_s;
  logic [3:0] beam_s;
  assign ext_s = sync2_q[12];
  assign hv_s = sync2_q[11];
  assign sched_s = sync2_q[10:6];
  assign beam_s = {sync2_q[3:2], sync2_q[4], sync2_q[5]};
  assign shut_s = sync2_q[1];
  assign start_s = sync2_q[0];
  // Acceptance time in cycles from the selector
  function automatic logic [19:0] acc_cycles(input logic [1:0] sel);
    if (sel == `LXIO_SEL_0P1MS) begin
      acc_cycles = 20'(`LXIO_US_CYC(`LXIO_ACC_0P1_US));
    end else if (sel == `LXIO_SEL_4MS) begin
      acc_cycles = 20'(`LXIO_US_CYC(`LXIO_ACC_4P0_US));
    end else if (sel == `LXIO_SEL_8MS) begin
      acc_cycles = 20'(`LXIO_US_CYC(`LXIO_ACC_8P0_US));
    end else begin
      acc_cycles = 20'(`LXIO_US_CYC(`LXIO_ACC_16_US));
    end
  endfunction : acc_cycles
  logic [19:0] acc_lim;
  assign acc_lim = acc_cycles(accept_sel);
  // Schedule qualifier state
  logic [4:0] sched_seen_q, sched_seen_d;
  logic [19:0] sched_cnt_q, sched_cnt_d;
  logic [4:0] sched_num_q, sched_num_d;
  // Schedule must be stable for the acceptance time
  always_comb begin
    sched_seen_d = sched_s;
    sched_cnt_d = sched_cnt_q;
    sched_num_d = sched_num_q;
    if (!ext_s) begin
      sched_cnt_d = '0;
    end else if (sched_s != sched_seen_q) begin
      sched_cnt_d = '0;
    end else if (sched_cnt_q + 20'h0_0001 >= acc_lim) begin
      sched_num_d = sched_s;
    end else begin
      sched_cnt_d = sched_cnt_q + 20'h0_0001;
    end
  end
  // Schedule registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sched_seen_q <= '0;
      sched_cnt_q <= '0;
      sched_num_q <= '0;
    end else begin
      sched_seen_q <= sched_seen_d;
      sched_cnt_q <= sched_cnt_d;
      sched_num_q <= sched_num_d;
    end
  end
  // Charge supervision state
  logic hv_on_q, hv_on_d, ready_q, ready_d;
  logic [31:0] chg_cnt_q, chg_cnt_d;
  // Ready on charge done or forced by charge limit
  always_comb begin
    hv_on_d = hv_s && ext_s;
    ready_d = ready_q;
    chg_cnt_d = chg_cnt_q;
    if (!(hv_s && ext_s)) begin
      ready_d = 1'b0;
      chg_cnt_d = '0;
    end else if (charge_done || chg_cnt_q + 32'h0000_0001 >= CHARGE_CYC) begin
      ready_d = 1'b1;
    end else begin
      chg_cnt_d = chg_cnt_q + 32'h0000_0001;
    end
  end
  // Charge registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hv_on_q <= 1'b0;
      ready_q <= 1'b0;
      chg_cnt_q <= '0;
    end else begin
      hv_on_q <= hv_on_d;
      ready_q <= ready_d;
      chg_cnt_q <= chg_cnt_d;
    end
  end
  // Emission sequencer state
  lxio_pkg::lxio_state_t st_q, st_d;
  logic [19:0] acc_cnt_q, acc_cnt_d;
  logic [31:0] post_cnt_q, post_cnt_d;
  logic [31:0] slot_cnt_q, slot_cnt_d;
  logic [1:0] slot_q, slot_d;
  logic emit_q, emit_d, end_q, end_d, mon_n_q, mon_n_d, mon_t_q, mon_t_d;
  logic [3:0] deliv_q, deliv_d;
  logic go;
  // Shutter is the controller's job to settle before start
  assign go = ext_s && start_s && ready_q && shut_s;
  // Main sequence: qualify, emit, post delay, done
  always_comb begin
    st_d = st_q;
    acc_cnt_d = acc_cnt_q;
    post_cnt_d = post_cnt_q;
    slot_cnt_d = slot_cnt_q;
    slot_d = slot_q;
    emit_d = 1'b0;
    end_d = end_q;
    mon_n_d = mon_n_q;
    mon_t_d = mon_t_q;
    deliv_d = 4'h0;
    case (st_q)
      lxio_pkg::LXIO_IDLE: begin
        acc_cnt_d = '0;
        if (go) begin
          st_d = lxio_pkg::LXIO_QUAL;
          end_d = 1'b0;
          mon_n_d = 1'b0;
          mon_t_d = 1'b0;
        end
      end
      lxio_pkg::LXIO_QUAL: begin
        if (!go) begin
          st_d = lxio_pkg::LXIO_IDLE;
        end else if (acc_cnt_q + 20'h0_0001 >= acc_lim) begin
          st_d = lxio_pkg::LXIO_EMIT;
          slot_cnt_d = '0;
          slot_d = 2'h0;
        end else begin
          acc_cnt_d = acc_cnt_q + 20'h0_0001;
        end
      end
      lxio_pkg::LXIO_EMIT: begin
        if (!go) begin
          st_d = lxio_pkg::LXIO_POST;
          post_cnt_d = '0;
        end else begin
          emit_d = 1'b1;
          if (time_shared_mode) begin
            // One unit at a time, stepping all four slots; a slot whose unit is unselected lights none
            deliv_d = beam_s & (4'h1 << slot_q);
            if (slot_cnt_q + 32'h0000_0001 >= SLOT_CYC) begin
              slot_cnt_d = '0;
              slot_d = slot_q + 2'h1;
            end else begin
              slot_cnt_d = slot_cnt_q + 32'h0000_0001;
            end
          end else begin
            deliv_d = beam_s;
          end
        end
      end
      lxio_pkg::LXIO_POST: begin
        if (post_cnt_q + 32'h0000_0001 >= POST_CYC) begin
          st_d = lxio_pkg::LXIO_DONE;
          end_d = 1'b1;
          mon_n_d = (pulse_energy >= energy_low_limit) &&
                    (pulse_energy <= energy_high_limit);
          mon_t_d = !((pulse_energy >= energy_low_limit) &&
                      (pulse_energy <= energy_high_limit));
        end else begin
          post_cnt_d = post_cnt_q + 32'h0000_0001;
        end
      end
      lxio_pkg::LXIO_DONE: begin
        if (!start_s) begin
          st_d = lxio_pkg::LXIO_IDLE;
        end
      end
      default: begin
        st_d = lxio_pkg::LXIO_IDLE;
      end
    endcase
  end
  // Sequencer registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= lxio_pkg::LXIO_IDLE;
      acc_cnt_q <= '0;
      post_cnt_q <= '0;
      slot_cnt_q <= '0;
      slot_q <= 2'h0;
      emit_q <= 1'b0;
      end_q <= 1'b0;
      mon_n_q <= 1'b0;
      mon_t_q <= 1'b0;
      deliv_q <= 4'h0;
    end else begin
      st_q <= st_d;
      acc_cnt_q <= acc_cnt_d;
      post_cnt_q <= post_cnt_d;
      slot_cnt_q <= slot_cnt_d;
      slot_q <= slot_d;
      emit_q <= emit_d;
      end_q <= end_d;
      mon_n_q <= mon_n_d;
      mon_t_q <= mon_t_d;
      deliv_q <= deliv_d;
    end
  end
  // Receivable flag registered
  logic recv_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      recv_q <= 1'b0;
    end else begin
      recv_q <= ext_s;
    end
  end
  // Outputs straight from flip-flops
  assign ext_receivable = recv_q;
  assign high_voltage_on = hv_on_q;
  assign ready = ready_q;
  assign end_out = end_q;
  assign monitor_normal = mon_n_q;
  assign monitor_trouble = mon_t_q;
  assign schedule_number = sched_num_q;
  assign delivery_enable = deliv_q;
  assign emission = emit_q;
endmodule : lxio_sequencer
`default_nettype wire

// [shared/lxio_defines.svh]
// Timing constants for the laser external I/O sequencer
`ifndef LXIO_DEFINES_SVH
`define LXIO_DEFINES_SVH
`define LXIO_CLK_HZ 20000000
`define LXIO_CHARGE_MAX_MS 31000
`define LXIO_CHARGE_CYC ((`LXIO_CHARGE_MAX_MS / 1000) * `LXIO_CLK_HZ)
`define LXIO_ACC_0P1_US 100
`define LXIO_ACC_4P0_US 4000
`define LXIO_ACC_8P0_US 8000
`define LXIO_ACC_16_US 16000
`define LXIO_US_CYC(us) (((us) * (`LXIO_CLK_HZ / 1000000)))
`define LXIO_POST_MS 40
`define LXIO_POST_CYC (`LXIO_POST_MS * (`LXIO_CLK_HZ / 1000))
`define LXIO_SEL_16MS 2'h0
`define LXIO_SEL_0P1MS 2'h1
`define LXIO_SEL_4MS 2'h2
`define LXIO_SEL_8MS 2'h3
`endif

// [shared/lxio_pkg.sv]
// Types for the laser external I/O sequencer
package lxio_pkg;
  typedef enum logic [4:0] {
    LXIO_IDLE = 5'b0_0001,
    LXIO_QUAL = 5'b0_0010,
    LXIO_EMIT = 5'b0_0100,
    LXIO_POST = 5'b0_1000,
    LXIO_DONE = 5'b1_0000
  } lxio_state_t;
endpackage : lxio_pkg
